// ===== trg_pkg.sv
package trg_pkg;

  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned FREERUN_NS    = 400000;
  localparam int unsigned FREERUN_CYC   = FREERUN_NS / CLK_PERIOD_NS;
  localparam int unsigned REARM_NS      = 5000;
  localparam int unsigned REARM_CYC     =
    (REARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Internal period is held in units of the fine step.
  localparam int unsigned RATE_UNIT_NS  = 4;
  localparam int unsigned RATE_STEP     = CLK_PERIOD_NS / RATE_UNIT_NS;
  localparam int unsigned PER_MIN_NS    = 8;
  localparam int unsigned PER_MAX_NS    = 60000000;
  localparam int unsigned PER_W         = 24;
  localparam logic [23:0] PER_MIN       = 24'(PER_MIN_NS / RATE_UNIT_NS);
  localparam logic [23:0] PER_MAX       = 24'(PER_MAX_NS / RATE_UNIT_NS);
  localparam logic [23:0] PER_RST       = 24'h0000FA;

  localparam int unsigned LEVEL_W       = 11;
  localparam logic signed [10:0] LEVEL_MIN = -11'sd1000;
  localparam logic signed [10:0] LEVEL_MAX = 11'sd1000;
  localparam logic signed [10:0] LEVEL_RST = 11'sd0;
  localparam logic signed [10:0] LEVEL_ZERO = 11'sd0;

  localparam logic [15:0] RECLEN_RST    = 16'h0200;

  localparam logic [7:0] OFF_CTRL       = 8'h00;
  localparam logic [7:0] OFF_LEVEL      = 8'h04;
  localparam logic [7:0] OFF_PERIOD     = 8'h08;
  localparam logic [7:0] OFF_RECLEN     = 8'h0C;
  localparam logic [7:0] OFF_STATUS     = 8'h10;

  localparam int unsigned CB_RUN        = 0;
  localparam int unsigned CB_SINGLE     = 1;
  localparam int unsigned CB_FREERUN    = 2;
  localparam int unsigned CB_HSENS      = 3;
  localparam int unsigned CB_NEG        = 4;
  localparam int unsigned CB_DIV        = 5;
  localparam int unsigned CB_SRC        = 8;
  localparam int unsigned CB_CHEN       = 12;

  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  localparam int unsigned PIN_EXT_THR   = 0;
  localparam int unsigned PIN_EXT_ARM   = 1;
  localparam int unsigned PIN_CH1_THR   = 2;
  localparam int unsigned PIN_CH1_ARM   = 3;
  localparam int unsigned PIN_CH2_THR   = 4;
  localparam int unsigned PIN_CH2_ARM   = 5;
  localparam int unsigned PIN_PRESCALE  = 6;
  localparam int unsigned PIN_CLK_REC   = 7;
  localparam int unsigned NUM_PINS      = 8;

  typedef enum logic [2:0] {
    SRC_EXT_DIRECT   = 3'b000,
    SRC_EXT_PRESCALE = 3'b001,
    SRC_FIRST_CH     = 3'b010,
    SRC_SECOND_CH    = 3'b011,
    SRC_INTERNAL     = 3'b100,
    SRC_CLK_REC      = 3'b101
  } trg_src_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARMED = 2'b01,
    ST_REARM = 2'b10
  } trg_state_t;

endpackage

// ===== trg_rate_gen.sv
`timescale 1ns/1ps
module trg_rate_gen #(
  parameter int unsigned PER_W = 24
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic             en,
  input  wire logic [PER_W-1:0] period,
  output logic                  tick
);

  logic [PER_W:0] acc_q;
  logic [PER_W:0] sum;
  logic [PER_W:0] rem;
  logic [PER_W:0] per_x;

  if (PER_W < 8)
  begin : g_bad_width
    $error("PER_W too narrow for the phase step");
  end

  // A phase accumulator keeps the 4 ns resolution on average even though
  // each tick can only land on a 40 ns edge.
  always_comb
  begin
    per_x = {1'b0, period};
    sum   = acc_q + (PER_W+1)'(trg_pkg::RATE_STEP);
    rem   = sum - per_x;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      acc_q <= '0;
      tick  <= 1'b0;
    end
    else if (!en)
    begin
      acc_q <= '0;
      tick  <= 1'b0;
    end
    else if (sum >= per_x)
    begin
      tick  <= 1'b1;
      acc_q <= (rem >= per_x) ? '0 : rem;
    end
    else
    begin
      tick  <= 1'b0;
      acc_q <= sum;
    end
  end

endmodule

// ===== trg_top.sv
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module trg_top #(
  parameter bit          HAS_CLK_REC    = 1'b1,
  parameter int unsigned NUM_CHANNELS   = 2,
  parameter int unsigned FREERUN_CYCLES = trg_pkg::FREERUN_CYC,
  parameter int unsigned ADDR_W         = 8
) (
  input  wire logic              mclk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              cmp_ext_thr,
  input  wire logic              cmp_ext_arm,
  input  wire logic              cmp_ch1_thr,
  input  wire logic              cmp_ch1_arm,
  input  wire logic              cmp_ch2_thr,
  input  wire logic              cmp_ch2_arm,
  input  wire logic              prescale_in,
  input  wire logic              clk_rec_in,
  output logic                   acq_trig,
  output logic                   step_pulse,
  output logic signed [10:0]     thr_level,
  output logic                   hyst_off
);

  localparam int unsigned TO_W = $clog2(FREERUN_CYCLES + 1);

  if (NUM_CHANNELS != 2 && NUM_CHANNELS != 4)
  begin : g_bad_channels
    $error("NUM_CHANNELS must be 2 or 4");
  end
  if (ADDR_W < 8)
  begin : g_bad_addr
    $error("ADDR_W too small for the register map");
  end
  if (FREERUN_CYCLES < 2)
  begin : g_bad_timeout
    $error("FREERUN_CYCLES must be at least 2");
  end

  // Register bus.
  logic              aw_got_q;
  logic              w_got_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              wr_go;
  logic [7:0]        wr_off;
  logic [7:0]        rd_off;
  logic [31:0]       wr_val;
  logic [31:0]       old_val;
  logic [31:0]       ctrl_rd;
  logic [31:0]       stat_rd;
  logic              wr_map;

  // Software settings.
  logic                     run_q;
  logic                     single_q;
  logic                     freerun_q;
  logic                     hsens_q;
  logic                     neg_q;
  logic [1:0]               div_q;
  trg_pkg::trg_src_t        src_q;
  logic [3:0]               chen_q;
  logic signed [10:0]       level_q;
  logic [trg_pkg::PER_W-1:0] period_q;
  logic [15:0]              reclen_q;

  // Settings in force since the last arming point.
  trg_pkg::trg_src_t        act_src_q;
  logic                     act_free_q;
  logic                     act_hs_q;
  logic                     act_neg_q;
  logic [1:0]               act_div_q;
  logic [trg_pkg::PER_W-1:0] act_per_q;

  trg_pkg::trg_state_t      state_q;
  logic [7:0]               rearm_q;
  logic [TO_W-1:0]          to_q;
  logic [15:0]              pt_q;
  logic                     forced_last_q;
  logic                     arm_seen_q;
  logic [2:0]               pre_cnt_q;

  logic [trg_pkg::NUM_PINS-1:0] pins;
  logic [trg_pkg::NUM_PINS-1:0] s1_q;
  logic [trg_pkg::NUM_PINS-1:0] s2_q;
  logic [trg_pkg::NUM_PINS-1:0] prev_q;

  logic       arm_ok;
  logic       arm_enter;
  logic       rearm_done;
  logic       direct;
  logic       thr_now;
  logic       thr_was;
  logic       arm_hi;
  logic       edge_hit;
  logic       pre_tick;
  logic [2:0] pre_lim;
  logic       gen_en;
  logic       gen_tick;
  logic       qual;
  logic       forced;
  logic       accept;
  logic       rec_done;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction

  // Write channel: address and data are taken in either order.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      awready  <= 1'b0;
      wready   <= 1'b0;
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= '0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
      bvalid   <= 1'b0;
      bresp    <= trg_pkg::RESP_OKAY;
    end
    else
    begin
      if (awready && awvalid)
      begin
        awready  <= 1'b0;
        aw_got_q <= 1'b1;
        awaddr_q <= awaddr;
      end
      else if (!aw_got_q && !bvalid)
        awready <= 1'b1;
      if (wready && wvalid)
      begin
        wready  <= 1'b0;
        w_got_q <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      else if (!w_got_q && !bvalid)
        wready <= 1'b1;
      if (wr_go)
      begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid   <= 1'b1;
        bresp    <= wr_map ? trg_pkg::RESP_OKAY : trg_pkg::RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  always_comb
  begin
    wr_go  = aw_got_q && w_got_q && !bvalid;
    wr_off = {awaddr_q[7:2], 2'b00};
    rd_off = {araddr[7:2], 2'b00};
    wr_map = (awaddr_q[ADDR_W-1:5] == '0) &&
             (wr_off <= trg_pkg::OFF_STATUS);
    unique case (wr_off)
      trg_pkg::OFF_CTRL:   old_val = ctrl_rd;
      trg_pkg::OFF_LEVEL:  old_val = {{21{level_q[10]}}, level_q};
      trg_pkg::OFF_PERIOD: old_val = {8'h00, period_q};
      trg_pkg::OFF_RECLEN: old_val = {16'h0000, reclen_q};
      default:             old_val = '0;
    endcase
    wr_val  = merge(old_val, wdata_q, wstrb_q);
    ctrl_rd = {16'h0000, chen_q, 1'b0, src_q, 1'b0, div_q, neg_q,
               hsens_q, freerun_q, single_q, run_q};
    stat_rd = {pt_q, 13'h0000, forced_last_q, state_q};
  end

  // Read channel answers one cycle after the address is taken.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= trg_pkg::RESP_OKAY;
    end
    else if (arready && arvalid)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= trg_pkg::RESP_OKAY;
      unique case (rd_off)
        trg_pkg::OFF_CTRL:   rdata <= ctrl_rd;
        trg_pkg::OFF_LEVEL:  rdata <= {{21{level_q[10]}}, level_q};
        trg_pkg::OFF_PERIOD: rdata <= {8'h00, period_q};
        trg_pkg::OFF_RECLEN: rdata <= {16'h0000, reclen_q};
        trg_pkg::OFF_STATUS: rdata <= stat_rd;
        default:
        begin
          rdata <= '0;
          rresp <= trg_pkg::RESP_SLVERR;
        end
      endcase
      if (araddr[ADDR_W-1:5] != '0)
      begin
        rdata <= '0;
        rresp <= trg_pkg::RESP_SLVERR;
      end
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
    else if (!rvalid)
      arready <= 1'b1;
  end

  // Settings registers.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      run_q     <= 1'b0;
      freerun_q <= 1'b0;
      hsens_q   <= 1'b0;
      neg_q     <= 1'b0;
      div_q     <= 2'h0;
      src_q     <= trg_pkg::SRC_EXT_DIRECT;
      chen_q    <= 4'h0;
      level_q   <= trg_pkg::LEVEL_RST;
      period_q  <= trg_pkg::PER_RST;
      reclen_q  <= trg_pkg::RECLEN_RST;
    end
    else if (wr_go && wr_off == trg_pkg::OFF_CTRL && wr_map)
    begin
      run_q     <= wr_val[trg_pkg::CB_RUN];
      freerun_q <= wr_val[trg_pkg::CB_FREERUN];
      hsens_q   <= wr_val[trg_pkg::CB_HSENS];
      neg_q     <= wr_val[trg_pkg::CB_NEG];
      div_q     <= wr_val[trg_pkg::CB_DIV +: 2];
      // Only channels that exist and are fitted can be enabled.
      chen_q    <= wr_val[trg_pkg::CB_CHEN +: 4] &
                   ((NUM_CHANNELS == 4) ? 4'hF : 4'h3);
      // An unknown source code, or clock recovery on a unit without it,
      // leaves the previous source in place.
      if (wr_val[trg_pkg::CB_SRC +: 3] <= 3'h5 &&
          (HAS_CLK_REC ||
           wr_val[trg_pkg::CB_SRC +: 3] != trg_pkg::SRC_CLK_REC))
        src_q <= trg_pkg::trg_src_t'(wr_val[trg_pkg::CB_SRC +: 3]);
    end
    else if (wr_go && wr_off == trg_pkg::OFF_LEVEL && wr_map)
    begin
      if ($signed(wr_val) < $signed(32'(trg_pkg::LEVEL_MIN)))
        level_q <= trg_pkg::LEVEL_MIN;
      else if ($signed(wr_val) > $signed(32'(trg_pkg::LEVEL_MAX)))
        level_q <= trg_pkg::LEVEL_MAX;
      else
        level_q <= wr_val[10:0];
    end
    else if (wr_go && wr_off == trg_pkg::OFF_PERIOD && wr_map)
    begin
      if (wr_val[23:0] < trg_pkg::PER_MIN)
        period_q <= trg_pkg::PER_MIN;
      else if (wr_val[31:24] != 8'h00 || wr_val[23:0] > trg_pkg::PER_MAX)
        period_q <= trg_pkg::PER_MAX;
      else
        period_q <= wr_val[23:0];
    end
    else if (wr_go && wr_off == trg_pkg::OFF_RECLEN && wr_map)
      reclen_q <= (wr_val[15:0] == 16'h0000) ? 16'h0001 : wr_val[15:0];
  end

  // Single acquisition: a software start wins over the end of record.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      single_q <= 1'b0;
    else if (wr_go && wr_map && wr_off == trg_pkg::OFF_CTRL)
      single_q <= wr_val[trg_pkg::CB_SINGLE] | (single_q & ~rec_done);
    else if (rec_done)
      single_q <= 1'b0;
  end

  // Comparator and trigger pins come from another domain.
  assign pins = {clk_rec_in, prescale_in, cmp_ch2_arm, cmp_ch2_thr,
                 cmp_ch1_arm, cmp_ch1_thr, cmp_ext_arm, cmp_ext_thr};

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_q   <= '0;
      s2_q   <= '0;
      prev_q <= '0;
    end
    else
    begin
      s1_q   <= pins;
      s2_q   <= s1_q;
      prev_q <= s2_q;
    end
  end

  always_comb
  begin
    arm_ok     = (run_q || single_q) && (chen_q != 4'h0);
    rearm_done = (rearm_q == 8'(trg_pkg::REARM_CYC - 1));
    arm_enter  = arm_ok && (state_q == trg_pkg::ST_IDLE ||
                 (state_q == trg_pkg::ST_REARM && rearm_done));
    direct     = 1'b1;
    thr_now    = 1'b0;
    thr_was    = 1'b0;
    arm_hi     = 1'b0;
    unique case (act_src_q)
      trg_pkg::SRC_EXT_DIRECT:
      begin
        thr_now = s2_q[trg_pkg::PIN_EXT_THR];
        thr_was = prev_q[trg_pkg::PIN_EXT_THR];
        arm_hi  = s2_q[trg_pkg::PIN_EXT_ARM];
      end
      trg_pkg::SRC_FIRST_CH:
      begin
        thr_now = s2_q[trg_pkg::PIN_CH1_THR];
        thr_was = prev_q[trg_pkg::PIN_CH1_THR];
        arm_hi  = s2_q[trg_pkg::PIN_CH1_ARM];
      end
      trg_pkg::SRC_SECOND_CH:
      begin
        thr_now = s2_q[trg_pkg::PIN_CH2_THR];
        thr_was = prev_q[trg_pkg::PIN_CH2_THR];
        arm_hi  = s2_q[trg_pkg::PIN_CH2_ARM];
      end
      default:
        direct = 1'b0;
    endcase
    // A comparator high means the source is above the level.
    edge_hit = act_neg_q ? (thr_was && !thr_now)
                         : (!thr_now && thr_was) == 1'b0 &&
                           (thr_now && !thr_was);
    unique case (act_div_q)
      2'h0: pre_lim = 3'h0;
      2'h1: pre_lim = 3'h1;
      2'h2: pre_lim = 3'h3;
      2'h3: pre_lim = 3'h7;
    endcase
    pre_tick = s2_q[trg_pkg::PIN_PRESCALE] &&
               !prev_q[trg_pkg::PIN_PRESCALE] && pre_cnt_q == pre_lim;
    gen_en   = (run_q || single_q) &&
               act_src_q == trg_pkg::SRC_INTERNAL;
    unique case (act_src_q)
      trg_pkg::SRC_EXT_PRESCALE: qual = pre_tick;
      trg_pkg::SRC_INTERNAL:     qual = gen_tick;
      trg_pkg::SRC_CLK_REC:
        qual = s2_q[trg_pkg::PIN_CLK_REC] && !prev_q[trg_pkg::PIN_CLK_REC];
      default:
        qual = direct && edge_hit && (act_hs_q || arm_seen_q);
    endcase
    forced   = act_free_q && !qual &&
               to_q == TO_W'(FREERUN_CYCLES - 1);
    accept   = state_q == trg_pkg::ST_ARMED && (qual || forced);
    rec_done = accept && pt_q >= reclen_q - 16'h0001;
  end

  trg_rate_gen #(
    .PER_W (trg_pkg::PER_W)
  ) u_rate (
    .mclk   (mclk),
    .resetn (resetn),
    .en     (gen_en),
    .period (act_per_q),
    .tick   (gen_tick)
  );

  // Arming state machine.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= trg_pkg::ST_IDLE;
      rearm_q <= 8'h00;
    end
    else if (!arm_ok)
      state_q <= trg_pkg::ST_IDLE;
    else
      unique case (state_q)
        trg_pkg::ST_IDLE:
          state_q <= trg_pkg::ST_ARMED;
        trg_pkg::ST_ARMED:
          if (accept)
          begin
            state_q <= trg_pkg::ST_REARM;
            rearm_q <= 8'h00;
          end
        trg_pkg::ST_REARM:
          if (rearm_done)
            state_q <= trg_pkg::ST_ARMED;
          else
            rearm_q <= rearm_q + 8'h01;
        default:
          state_q <= trg_pkg::ST_IDLE;
      endcase
  end

  // Settings are copied only where arming begins, so a change other than the level never lands
  // in the middle of a qualification already under way.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      act_src_q  <= trg_pkg::SRC_EXT_DIRECT;
      act_free_q <= 1'b0;
      act_hs_q   <= 1'b0;
      act_neg_q  <= 1'b0;
      act_div_q  <= 2'h0;
      act_per_q  <= trg_pkg::PER_RST;
    end
    else if (arm_enter)
    begin
      act_src_q  <= src_q;
      act_free_q <= freerun_q;
      act_hs_q   <= hsens_q;
      act_neg_q  <= neg_q;
      act_div_q  <= div_q;
      act_per_q  <= period_q;
    end
  end

  // Qualification state: arming crossing, divider phase, timeout.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      arm_seen_q <= 1'b0;
      pre_cnt_q  <= 3'h0;
      to_q       <= '0;
    end
    else
    begin
      if (arm_enter || accept)
        arm_seen_q <= 1'b0;
      else if (state_q == trg_pkg::ST_ARMED &&
               (act_neg_q ? arm_hi : !arm_hi))
        arm_seen_q <= 1'b1;
      if (arm_enter)
        pre_cnt_q <= 3'h0;
      else if (s2_q[trg_pkg::PIN_PRESCALE] &&
               !prev_q[trg_pkg::PIN_PRESCALE])
        pre_cnt_q <= (pre_cnt_q == pre_lim) ? 3'h0 : pre_cnt_q + 3'h1;
      if (arm_enter || state_q != trg_pkg::ST_ARMED || accept)
        to_q <= '0;
      else if (act_free_q)
        to_q <= to_q + TO_W'(1);
    end
  end

  // Outputs to the sequencer and front end.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      acq_trig      <= 1'b0;
      step_pulse    <= 1'b0;
      thr_level     <= trg_pkg::LEVEL_ZERO;
      hyst_off      <= 1'b0;
      pt_q          <= 16'h0000;
      forced_last_q <= 1'b0;
    end
    else
    begin
      acq_trig   <= accept;
      step_pulse <= gen_tick;
      thr_level  <= (act_src_q == trg_pkg::SRC_EXT_PRESCALE) ?
                    trg_pkg::LEVEL_ZERO : level_q;
      hyst_off   <= act_hs_q && direct;
      if (accept)
      begin
        pt_q          <= rec_done ? 16'h0000 : pt_q + 16'h0001;
        forced_last_q <= forced;
      end
      // A stop starts a fresh record, so a shorter length takes effect.
      else if (state_q == trg_pkg::ST_IDLE)
        pt_q <= 16'h0000;
    end
  end

endmodule

// ===== trg_top_assertions.sv
`timescale 1ns/1ps
module trg_chk (
  input wire logic               mclk,
  input wire logic               resetn,
  input wire logic               acq_trig,
  input wire logic signed [10:0] thr_level,
  input wire logic [1:0]         bresp,
  input wire logic               bvalid,
  input wire logic               bready,
  input wire logic               awready,
  input wire logic               wready,
  input wire logic               arvalid,
  input wire logic               arready,
  input wire logic [31:0]        rdata,
  input wire logic               rvalid,
  input wire logic               rready
);
  logic [7:0] gap_q;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  // Cycles since the last trigger; it saturates so long idle never wraps.
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
      gap_q <= 8'hFF;
    else if (acq_trig)
      gap_q <= 8'h00;
    else if (gap_q != 8'hFF)
      gap_q <= gap_q + 8'h01;
  a_trig_one_cycle: assert property (acq_trig |=> !acq_trig)
    else $error("trigger pulse longer than one cycle");
  a_rearm_gap_held: assert property (acq_trig |-> gap_q >= 8'h7D)
    else $error("trigger accepted inside rearm interval");
  a_level_in_span: assert property (thr_level >= -11'sd1000 &&
    thr_level <= 11'sd1000)
    else $error("threshold outside span");
  a_bresp_stands: assert property (bvalid && !bready |=>
    bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_rdata_stands: assert property (rvalid && !rready |=>
    rvalid && $stable(rdata))
    else $error("read data dropped early");
  a_write_blocked: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted during response");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_ready_return: assert property ($fell(bvalid) |=> awready && wready)
    else $error("write ready not restored");
endmodule

bind trg_top trg_chk trg_chk_i (.mclk, .resetn, .acq_trig, .thr_level,
  .bresp, .bvalid, .bready, .awready, .wready, .arvalid, .arready, .rdata,
  .rvalid, .rready);

// ===== trg_fe_model.sv
`timescale 1ns/1ps
module trg_fe_model (
  input wire logic  mclk,
  input wire logic  acq_trig,
  input wire logic  step_pulse,
  output logic [7:0] pins
);
  int n_acq = 0;
  int n_step = 0;
  initial pins = 8'h00;
  always @(posedge mclk) if (acq_trig) n_acq++;
  always @(posedge mclk) if (step_pulse) n_step++;
  // Holds each level long enough to pass the input synchroniser.
  task automatic drive(input int p, input logic v);
    @(posedge mclk);
    pins[p] <= v;
    repeat (6) @(posedge mclk);
  endtask
endmodule

// ===== tb_trg_top.sv
`timescale 1ns/1ps
module tb_trg_top;
  logic               mclk = 1'h0, resetn = 1'h0;
  logic [7:0]         awaddr = 8'h00, araddr = 8'h00, pins;
  logic [31:0]        wdata = 32'h0, rdata, rd_q;
  logic [2:0]         awprot = 3'h0, arprot = 3'h0;
  logic [3:0]         wstrb = 4'hF;
  logic               awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic               arvalid = 1'h0, rready = 1'h0, awready, wready;
  logic               bvalid, arready, rvalid, acq_trig, step_pulse;
  logic               hyst_off;
  logic [1:0]         bresp, rresp, resp_q;
  logic signed [10:0] thr_level;
  logic [31:0]        rst_v [5] = '{32'h0, 32'h0, 32'hFA, 32'h200, 32'h0};
  int                 error_cnt = 0, n_checks = 0, cyc = 0, base;
  trg_top #(.FREERUN_CYCLES(50)) trg_top_i (
    .mclk, .resetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready,
    .cmp_ext_thr(pins[0]), .cmp_ext_arm(pins[1]), .cmp_ch1_thr(pins[2]),
    .cmp_ch1_arm(pins[3]), .cmp_ch2_thr(pins[4]), .cmp_ch2_arm(pins[5]),
    .prescale_in(pins[6]), .clk_rec_in(pins[7]), .acq_trig, .step_pulse,
    .thr_level, .hyst_off);
  trg_fe_model trg_fe_model_i (.mclk, .acq_trig, .step_pulse, .pins);
  always #20 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge mclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      resp_q = bresp;
    end while (!bvalid);
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge mclk);
      if (arready) arvalid <= 1'h0;
      rd_q = rdata;
      resp_q = rresp;
    end while (!rvalid);
    rready <= 1'h0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    rd(a);
    chk(nm, e, rd_q);
  endtask
  // Stops first so the new settings are taken at a fresh arming.
  task automatic ctl(input logic [31:0] v);
    wr(trg_pkg::OFF_CTRL, 32'h0);
    repeat (140) @(posedge mclk);
    wr(trg_pkg::OFF_CTRL, v);
  endtask
  task automatic dr(input int p, input logic v);
    trg_fe_model_i.drive(p, v);
  endtask
  task automatic ac(input int e);
    chk("trigger count", 32'(e), 32'(trg_fe_model_i.n_acq));
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge mclk);
    resetn <= 1'h1;
    foreach (rst_v[i]) rc(8'(i * 4), rst_v[i], "reset value");
    rd(8'h14);
    chk("read resp", 32'h2, {30'h0, resp_q});
    wr(8'h14, 32'h1);
    chk("write resp", 32'h2, {30'h0, resp_q});
    wr(trg_pkg::OFF_LEVEL, 32'hFFFFEC78);
    rc(trg_pkg::OFF_LEVEL, 32'hFFFFFC18, "level low");
    wr(trg_pkg::OFF_LEVEL, 32'h7D0);
    rc(trg_pkg::OFF_LEVEL, 32'h3E8, "level high");
    wr(trg_pkg::OFF_PERIOD, 32'h1);
    rc(trg_pkg::OFF_PERIOD, 32'h2, "period low");
    wr(trg_pkg::OFF_PERIOD, 32'hFFFFFF);
    rc(trg_pkg::OFF_PERIOD, 32'hE4E1C0, "period high");
    $display("test registers done");
    ctl(32'h0009);
    dr(0, 1'h1);
    ac(0);
    dr(0, 1'h0);
    ctl(32'h1009);
    repeat (2) @(posedge mclk);
    chk("level out", 32'h3E8, {21'h0, thr_level});
    chk("hyst off", 32'h1, {31'h0, hyst_off});
    dr(0, 1'h1);
    ac(1);
    repeat (140) @(posedge mclk);
    dr(0, 1'h0);
    ac(1);
    ctl(32'h1019);
    dr(0, 1'h1);
    ac(1);
    dr(0, 1'h0);
    ac(2);
    dr(1, 1'h1);
    ctl(32'h1001);
    dr(0, 1'h1);
    ac(2);
    dr(0, 1'h0);
    dr(1, 1'h0);
    dr(1, 1'h1);
    dr(0, 1'h1);
    ac(3);
    ctl(32'h1309);
    dr(2, 1'h1);
    ac(3);
    dr(4, 1'h1);
    ac(4);
    $display("test edge done");
    ctl(32'h1161);
    repeat (2) @(posedge mclk);
    chk("level prescale", 32'h0, {21'h0, thr_level});
    repeat (7)
    begin
      dr(6, 1'h1);
      dr(6, 1'h0);
    end
    ac(4);
    dr(6, 1'h1);
    ac(5);
    ctl(32'h1005);
    repeat (100) @(posedge mclk);
    ac(6);
    rd(trg_pkg::OFF_STATUS);
    chk("self flag", 32'h4, rd_q & 32'h4);
    ctl(32'h1009);
    repeat (300) @(posedge mclk);
    ac(6);
    $display("test mode done");
    wr(trg_pkg::OFF_RECLEN, 32'h2);
    wr(trg_pkg::OFF_PERIOD, 32'h32);
    ctl(32'h1402);
    repeat (400) @(posedge mclk);
    ac(8);
    rc(trg_pkg::OFF_CTRL, 32'h1400, "single end");
    base = trg_fe_model_i.n_step;
    chk("steps seen", 32'h1, {31'h0, base > 10});
    repeat (50) @(posedge mclk);
    chk("steps stop", 32'(base), 32'(trg_fe_model_i.n_step));
    ctl(32'h1501);
    dr(7, 1'h1);
    ac(9);
    $display("test internal done");
    complete_run();
  end
endmodule
